// ==== pkg/power_seq_cfg.svh ====
// constants for the power-on start sequencer: timing, register map, fields
`ifndef POWER_SEQ_CFG_SVH
`define POWER_SEQ_CFG_SVH

// clock rate and documented intervals
`define CLK_MHZ            200
`define SETTLE_US          26
`define LOOP_US            80
`define BROWN_US           20
`define SETTLE_CYCLES      (`SETTLE_US * `CLK_MHZ)
`define LOOP_CYCLES        (`LOOP_US * `CLK_MHZ)
`define BROWN_CYCLES       (`BROWN_US * `CLK_MHZ)
`define ELAPSED_W          15
`define BROWN_W            12

// register map, byte addresses
`define ADDR_W             8
`define REG_CTRL           8'h00
`define REG_STATUS         8'h04
`define REG_IRQ_STATUS     8'h08
`define REG_IRQ_CLEAR      8'h0C
`define REG_IRQ_ENABLE     8'h10

// fields
`define CTRL_RESTART_BIT   0
`define IRQ_W              4
`define IRQ_LOOP_BIT       0
`define IRQ_BROWN_BIT      1
`define IRQ_LOW_BIT        2
`define IRQ_SEARCH_BIT     3
`define IRQ_EN_RESET       4'h0

// bus responses
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// ==== pkg/power_seq_pkg.sv ====
// types shared by the power-on start sequencer
package power_seq_pkg;
    typedef enum logic [2:0] {
        ST_POWER_WAIT,
        ST_SETTLE,
        ST_SENSOR_UP,
        ST_SEARCH,
        ST_DEGAUSS_CHK,
        ST_DEGAUSS,
        ST_LOOP_WAIT,
        ST_RUN
    } seq_state_t;
endpackage

// ==== pkg/supply_if.sv ====
// supply indications passed between sequencer and brownout filter
`timescale 1ns/1ps
interface supply_if;
    logic under_upper;
    logic brownout;
    modport filt (input under_upper, output brownout);
    modport seq  (output under_upper, input brownout);
endinterface

// ==== hdl/sync2.sv ====
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module sync2 #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         ce,
    // data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    // first stage feeds only the second stage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_r <= '0;
            q      <= '0;
        end else if (ce) begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule

// ==== hdl/brownout_filter.sv ====
// brownout filter: flags a dip below the upper threshold lasting too long
`timescale 1ns/1ps
`include "power_seq_cfg.svh"
module brownout_filter (
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic ce,
    // supply indications
    supply_if.filt    sup
);
    localparam logic [`BROWN_W-1:0] LIMIT = `BROWN_W'(`BROWN_CYCLES);
    logic [`BROWN_W-1:0] cnt_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r        <= '0;
            sup.brownout <= 1'b0;
        end else if (ce) begin
            if (!sup.under_upper) begin
                cnt_r        <= '0;
                sup.brownout <= 1'b0;  // short dips vanish here
            end else if (cnt_r == LIMIT) begin
                sup.brownout <= 1'b1;
            end else begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end

    brown_limit_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        sup.brownout |-> cnt_r == LIMIT)
        else $error("brownout flagged before the filter time");
    short_dip_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (ce && !sup.under_upper) |=> !sup.brownout)
        else $error("brownout flagged while supply was good");
endmodule

// ==== hdl/power_on_start_sequencer.sv ====
// power-on and brownout start sequencer with axi4-lite register access
//
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "power_seq_cfg.svh"
module power_on_start_sequencer #(
    parameter int SETTLE_CYCLES = `SETTLE_CYCLES,
    parameter int LOOP_CYCLES   = `LOOP_CYCLES
) (
    // clock, reset, enable
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic                ce,
    // supply comparators and front end
    input  wire logic                supply_above_upper,
    input  wire logic                supply_above_lower,
    input  wire logic                sensor_saturated,
    input  wire logic                search_done,
    input  wire logic                core_degauss_request,
    input  wire logic                degauss_done,
    input  wire logic                loop_drive_a,
    input  wire logic                loop_drive_b,
    // sequence outputs
    output logic                     sensor_power_en,
    output logic                     search_start,
    output logic                     degauss_start,
    output logic                     loop_enable,
    output logic                     coil_drive_a,
    output logic                     coil_drive_b,
    output logic                     fault_flag_n,
    output logic                     irq,
    // axi4-lite write
    input  wire logic [`ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    // axi4-lite read
    input  wire logic [`ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready
);
    localparam logic [`ELAPSED_W-1:0] SETTLE_CNT = SETTLE_CYCLES[`ELAPSED_W-1:0];
    localparam logic [`ELAPSED_W-1:0] LOOP_CNT   = LOOP_CYCLES[`ELAPSED_W-1:0];

    power_seq_pkg::seq_state_t state_r;
    logic [`ELAPSED_W-1:0]     elapsed_r;
    logic [7:0]                pins_s;
    logic                      above_upper_s;
    logic                      above_lower_s;
    logic                      saturated_s;
    logic                      search_done_s;
    logic                      degauss_req_s;
    logic                      degauss_done_s;
    logic                      drive_a_s;
    logic                      drive_b_s;
    logic                      low_trip;
    logic                      restart;
    logic                      soft_restart_r;
    logic [`IRQ_W-1:0]         irq_status_r;
    logic [`IRQ_W-1:0]         irq_en_r;
    logic [`IRQ_W-1:0]         irq_clr;
    logic [`IRQ_W-1:0]         events;
    logic [`ADDR_W-1:0]        awaddr_r;
    logic [31:0]               wdata_r;
    logic [3:0]                wstrb_r;
    logic                      do_write;

    // register decode shared by the read and write paths
    function automatic logic addr_hit(input logic [`ADDR_W-1:0] a);
        addr_hit = (a == `REG_CTRL) || (a == `REG_STATUS) || (a == `REG_IRQ_STATUS)
                || (a == `REG_IRQ_CLEAR) || (a == `REG_IRQ_ENABLE);
    endfunction

    // every pin is asynchronous to aclk
    sync2 #(.W(8)) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .d       ({supply_above_upper, supply_above_lower, sensor_saturated, search_done,
                   core_degauss_request, degauss_done, loop_drive_a, loop_drive_b}),
        .q       (pins_s)
    );
    assign {above_upper_s, above_lower_s, saturated_s, search_done_s,
            degauss_req_s, degauss_done_s, drive_a_s, drive_b_s} = pins_s;

    supply_if sup ();
    assign sup.under_upper = !above_upper_s;

    brownout_filter u_filt (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .sup     (sup)
    );

    // lower comparator trips with no filtering
    assign low_trip = !above_lower_s;
    // any reset source sends the sequence back to its start
    assign restart  = low_trip || sup.brownout || soft_restart_r;

    // sequence state machine
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= power_seq_pkg::ST_POWER_WAIT;
        end else if (ce) begin
            if (restart) begin
                state_r <= power_seq_pkg::ST_POWER_WAIT;
            end else begin
                unique case (state_r)
                    power_seq_pkg::ST_POWER_WAIT: begin
                        if (above_upper_s) state_r <= power_seq_pkg::ST_SETTLE;
                    end
                    // sensor power only after settle time
                    power_seq_pkg::ST_SETTLE: begin
                        if (elapsed_r >= SETTLE_CNT) state_r <= power_seq_pkg::ST_SENSOR_UP;
                    end
                    power_seq_pkg::ST_SENSOR_UP: begin
                        state_r <= saturated_s ? power_seq_pkg::ST_SEARCH
                                               : power_seq_pkg::ST_DEGAUSS_CHK;
                    end
                    power_seq_pkg::ST_SEARCH: begin
                        if (search_done_s) state_r <= power_seq_pkg::ST_DEGAUSS_CHK;
                    end
                    // degauss request picks the next step
                    power_seq_pkg::ST_DEGAUSS_CHK: begin
                        state_r <= degauss_req_s ? power_seq_pkg::ST_DEGAUSS
                                                 : power_seq_pkg::ST_LOOP_WAIT;
                    end
                    power_seq_pkg::ST_DEGAUSS: begin
                        if (degauss_done_s) state_r <= power_seq_pkg::ST_RUN;
                    end
                    // without degauss, loop enables at 80us
                    power_seq_pkg::ST_LOOP_WAIT: begin
                        if (elapsed_r >= LOOP_CNT) state_r <= power_seq_pkg::ST_RUN;
                    end
                    power_seq_pkg::ST_RUN: begin
                        state_r <= power_seq_pkg::ST_RUN;
                    end
                endcase
            end
        end
    end

    // elapsed time since power-on, saturating at the loop time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            elapsed_r <= '0;
        end else if (ce) begin
            if (restart || state_r == power_seq_pkg::ST_POWER_WAIT) begin
                elapsed_r <= '0;
            end else if (elapsed_r < LOOP_CNT) begin
                elapsed_r <= elapsed_r + 1'b1;
            end
        end
    end

    // outputs registered; coils forced low and fault low until run
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sensor_power_en <= 1'b0;
            search_start    <= 1'b0;
            degauss_start   <= 1'b0;
            loop_enable     <= 1'b0;
            coil_drive_a    <= 1'b0;
            coil_drive_b    <= 1'b0;
            fault_flag_n    <= 1'b0;
        end else if (ce) begin
            sensor_power_en <= state_r != power_seq_pkg::ST_POWER_WAIT
                            && state_r != power_seq_pkg::ST_SETTLE;
            search_start    <= state_r == power_seq_pkg::ST_SEARCH;
            degauss_start   <= state_r == power_seq_pkg::ST_DEGAUSS;
            loop_enable     <= state_r == power_seq_pkg::ST_RUN;
            coil_drive_a    <= state_r == power_seq_pkg::ST_RUN && drive_a_s;
            coil_drive_b    <= state_r == power_seq_pkg::ST_RUN && drive_b_s;
            fault_flag_n    <= state_r == power_seq_pkg::ST_RUN;
        end
    end

    // interrupt events, one cycle each
    always_comb begin
        events = '0;
        events[`IRQ_LOOP_BIT]   = ce && !restart
            && ((state_r == power_seq_pkg::ST_LOOP_WAIT && elapsed_r >= LOOP_CNT)
             || (state_r == power_seq_pkg::ST_DEGAUSS && degauss_done_s));
        events[`IRQ_BROWN_BIT]  = ce && sup.brownout
            && state_r != power_seq_pkg::ST_POWER_WAIT;
        events[`IRQ_LOW_BIT]    = ce && low_trip && state_r != power_seq_pkg::ST_POWER_WAIT;
        events[`IRQ_SEARCH_BIT] = ce && !restart && saturated_s
            && state_r == power_seq_pkg::ST_SENSOR_UP;
    end

    // sticky status; a new event beats a clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status_r <= '0;
            irq          <= 1'b0;
        end else if (ce) begin
            irq_status_r <= (irq_status_r & ~irq_clr) | events;
            irq          <= |(irq_status_r & irq_en_r);
        end
    end

    // write path: each channel's ready doubles as its empty flag
    assign do_write = ce && !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            awaddr_r      <= '0;
            wdata_r       <= '0;
            wstrb_r       <= '0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_r      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_r      <= s_axi_wdata;
                wstrb_r      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= addr_hit(awaddr_r) ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // write effects: only byte lane 0 carries control bits
    assign irq_clr = (do_write && awaddr_r == `REG_IRQ_CLEAR && wstrb_r[0])
                   ? wdata_r[`IRQ_W-1:0] : '0;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_en_r       <= `IRQ_EN_RESET;
            soft_restart_r <= 1'b0;
        end else if (ce) begin
            soft_restart_r <= do_write && awaddr_r == `REG_CTRL && wstrb_r[0]
                           && wdata_r[`CTRL_RESTART_BIT];
            if (do_write && awaddr_r == `REG_IRQ_ENABLE && wstrb_r[0]) begin
                irq_en_r <= wdata_r[`IRQ_W-1:0];
            end
        end
    end

    // read path: one read outstanding, data captured at address take
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= addr_hit(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
                unique case (s_axi_araddr)
                    `REG_STATUS:     s_axi_rdata <= {25'h000_0000, fault_flag_n, loop_enable,
                                                     sensor_power_en, 1'b0, state_r};
                    `REG_IRQ_STATUS: s_axi_rdata <= {28'h000_0000, irq_status_r};
                    `REG_IRQ_ENABLE: s_axi_rdata <= {28'h000_0000, irq_en_r};
                    default:         s_axi_rdata <= 32'h0000_0000;
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    por_start_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (ce && !restart && state_r == power_seq_pkg::ST_POWER_WAIT && above_upper_s)
        |=> (state_r == power_seq_pkg::ST_SETTLE && elapsed_r == '0))
        else $error("power-on did not start the sequence");
    settle_wait_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        $rose(sensor_power_en) |-> ($past(elapsed_r) >= SETTLE_CNT))
        else $error("sensor powered before settle time");
    search_launch_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (ce && !restart && state_r == power_seq_pkg::ST_SENSOR_UP && saturated_s)
        |=> state_r == power_seq_pkg::ST_SEARCH ##1 (!$past(ce) || search_start))
        else $error("saturation did not launch search");
    degauss_step_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (ce && !restart && state_r == power_seq_pkg::ST_DEGAUSS_CHK)
        |=> (state_r == ($past(degauss_req_s) ? power_seq_pkg::ST_DEGAUSS
                                              : power_seq_pkg::ST_LOOP_WAIT)))
        else $error("degauss request not followed");
    loop_time_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        $rose(loop_enable) && $past(state_r, 2) == power_seq_pkg::ST_LOOP_WAIT
        |-> $past(elapsed_r, 2) >= LOOP_CNT)
        else $error("loop enabled before 80us without degauss");
    hold_outputs_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        ($past(ce) && $past(state_r) != power_seq_pkg::ST_RUN)
        |-> (!coil_drive_a && !coil_drive_b && !fault_flag_n && !loop_enable))
        else $error("coil drive or fault released during start-up");
    low_reset_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (ce && low_trip) |=> state_r == power_seq_pkg::ST_POWER_WAIT)
        else $error("low supply did not reset at once");
    rerun_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (ce && sup.brownout) |=> (state_r == power_seq_pkg::ST_POWER_WAIT && elapsed_r == '0))
        else $error("brownout did not restart the sequence");
    timer_bound_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (elapsed_r <= LOOP_CNT) and (ce && state_r == power_seq_pkg::ST_SETTLE
        && !restart |=> elapsed_r == $past(elapsed_r) + 1'b1))
        else $error("interval counter misbehaved");

    reach_run_c: cover property (@(posedge aclk) disable iff (!aresetn) $rose(loop_enable));
    search_c: cover property (@(posedge aclk) disable iff (!aresetn) $rose(search_start));
    degauss_c: cover property (@(posedge aclk) disable iff (!aresetn) $rose(degauss_start));
    brownout_c: cover property (@(posedge aclk) disable iff (!aresetn)
        sup.brownout && loop_enable);
endmodule

// ==== test/front_end_model.sv ====
// fluxgate front end model: answers search and degauss steps late
`timescale 1ns/1ps
module front_end_model #(
    parameter int DLY = 10
) (
    // clock
    input  wire logic aclk,
    // step requests from the sequencer
    input  wire logic search_start,
    input  wire logic degauss_start,
    // completion indications
    output logic      search_done,
    output logic      degauss_done
);
    int n_s = 0;
    int n_d = 0;
    // done only after a real wait, so the sequencer must hold its step
    always @(posedge aclk) begin
        n_s <= search_start ? n_s + 1 : 0;
        n_d <= degauss_start ? n_d + 1 : 0;
    end
    // done stands only while the step is still requested
    assign search_done  = search_start && n_s > DLY;
    assign degauss_done = degauss_start && n_d > DLY;
endmodule

// ==== test/power_on_start_sequencer_tb.sv ====
// self-checking bench for the power-on start sequencer
`timescale 1ns/1ps
`include "power_seq_cfg.svh"
module power_on_start_sequencer_tb;
    logic aclk = 0, aresetn = 0, up = 0, lo = 1, sat = 0, dg = 0, sd, dd;
    logic sp, ss, ds, le, ca, cb, ff, irq, awr, wr_rdy, bv, arr, rv;
    logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
    logic ce = 1, drv_a = 1, drv_b = 0;
    logic [3:0] ws = 4'hf;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0000_0000, rd_d, v;
    logic [1:0] bresp, rresp, r;
    int n_fail = 0, compares = 0, ns, nl, s_s, s_d;
    // 200 MHz clock
    always #2.5 aclk = ~aclk;
    power_on_start_sequencer #(.SETTLE_CYCLES(20), .LOOP_CYCLES(60)) uut (
        .aclk(aclk), .aresetn(aresetn), .ce(ce), .supply_above_upper(up),
        .supply_above_lower(lo), .sensor_saturated(sat), .search_done(sd),
        .core_degauss_request(dg), .degauss_done(dd), .loop_drive_a(drv_a),
        .loop_drive_b(drv_b), .sensor_power_en(sp), .search_start(ss),
        .degauss_start(ds), .loop_enable(le), .coil_drive_a(ca), .coil_drive_b(cb),
        .fault_flag_n(ff), .irq(irq), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd_d), .s_axi_rresp(rresp),
        .s_axi_rvalid(rv), .s_axi_rready(rr));
    front_end_model #(.DLY(10)) fe (.aclk(aclk), .search_start(ss),
        .degauss_start(ds), .search_done(sd), .degauss_done(dd));
    // compare and count
    task check(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", nm, exp, got);
            n_fail++;
        end
    endtask
    // bus write; starts after a rising edge, readys and response taken at one
    task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
        logic ag, wg, b;
        @(posedge aclk);
        awa <= a;
        wd <= d;
        awv <= 1;
        wv <= 1;
        br <= 1;
        do begin
            @(posedge aclk);
            ag = awv && awr;
            wg = wv && wr_rdy;
            b = bv;
            rs = bresp;
            if (ag) awv <= 0;
            if (wg) wv <= 0;
        end while (!b);
        br <= 0;
    endtask
    // bus read
    task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
        logic ag, b;
        @(posedge aclk);
        ara <= a;
        arv <= 1;
        rr <= 1;
        do begin
            @(posedge aclk);
            ag = arv && arr;
            b = rv;
            d = rd_d;
            rs = rresp;
            if (ag) arv <= 0;
        end while (!b);
        rr <= 0;
    endtask
    // follow one sequence up to loop enable, watching coils and fault flag
    task run_seq();
        ns = 0;
        nl = 0;
        s_s = 0;
        s_d = 0;
        while (!le) begin
            @(negedge aclk);
            nl++;
            if (!sp) ns++;
            if (ss) s_s = 1;
            if (ds) s_d = 1;
            if (!le) check("coils_fault", {ca, cb, ff}, 0);
        end
    endtask
    task t_start();
        @(posedge aclk) up <= 1;
        run_seq();
        check("settle_time", ns >= 20 && ns <= 28, 1);
        check("loop_time", nl >= 60 && nl <= 68, 1);
        check("no_steps", {s_s[0], s_d[0]}, 0);
        repeat (4) @(negedge aclk);
        check("coils_run", {ca, cb, ff}, 3'b101);
        // ce low freezes the pins and outputs; afterwards coils follow the loop
        @(posedge aclk);
        ce <= 0;
        drv_a <= 0;
        drv_b <= 1;
        repeat (8) @(negedge aclk);
        check("ce_freeze", {ca, cb}, 2'b10);
        @(posedge aclk) ce <= 1;
        repeat (4) @(negedge aclk);
        check("coils_follow", {ca, cb}, 2'b01);
        // both drives high from here, so later sequences really test the hold
        @(posedge aclk) drv_a <= 1;
        rd(`REG_STATUS, v, r);
        check("status", v, 32'h0000_0077);
        $display("test start done");
    endtask
    task t_steps();
        sat <= 1;
        dg <= 1;
        wr(`REG_CTRL, 32'h0000_0001, r);
        while (le) @(negedge aclk);
        run_seq();
        check("search_seen", s_s, 1);
        check("degauss_seen", s_d, 1);
        rd(`REG_IRQ_STATUS, v, r);
        check("irq_search", v[3], 1);
        sat <= 0;
        dg <= 0;
        $display("test steps done");
    endtask
    task t_brown();
        wr(`REG_IRQ_ENABLE, 32'h0000_0002, r);
        up <= 0;
        repeat (3900) @(posedge aclk);
        up <= 1;
        repeat (8) @(negedge aclk);
        check("short_dip", {le, irq}, 2'b10);
        @(posedge aclk) up <= 0;
        repeat (4100) @(negedge aclk);
        check("long_dip", {le, ff, irq}, 3'b001);
        wr(`REG_IRQ_CLEAR, 32'h0000_0002, r);
        rd(`REG_IRQ_STATUS, v, r);
        check("irq_clear", {v[1], irq}, 0);
        @(posedge aclk) up <= 1;
        run_seq();
        check("rerun_time", nl >= 60 && nl <= 68, 1);
        $display("test brownout done");
    endtask
    task t_low();
        int n;
        // a write without byte lane 0 must leave the enable untouched
        @(posedge aclk) ws <= 4'he;
        wr(`REG_IRQ_ENABLE, 32'h0000_0004, r);
        rd(`REG_IRQ_ENABLE, v, r);
        check("lane_ignored", v, 32'h0000_0002);
        ws <= 4'hf;
        wr(`REG_IRQ_ENABLE, 32'h0000_0004, r);
        lo <= 0;
        repeat (2) @(posedge aclk);
        lo <= 1;
        n = 0;
        while (le && n < 20) begin
            @(negedge aclk);
            n++;
        end
        check("low_trip", n <= 6, 1);
        check("low_irq", irq, 1);
        run_seq();
        check("low_rerun", nl >= 60 && nl <= 68, 1);
        rd(8'h20, v, r);
        check("bad_read", v, 32'h0000_0000);
        check("bad_read_resp", r, `RESP_SLVERR);
        wr(8'h20, 32'h0000_0001, r);
        check("bad_write", r, `RESP_SLVERR);
        $display("test low voltage done");
    endtask
    // verdict
    task results();
        $display("checks %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        t_start();
        t_steps();
        t_brown();
        t_low();
        results();
    end
    // watchdog
    initial begin
        repeat (30000) @(posedge aclk);
        n_fail++;
        results();
    end
endmodule
